// File: ioe_pkg.sv
package ioe_pkg;
	// register map
	localparam logic [11:0] IOE_ACCESS_OFS = 12'h430;
	localparam logic [11:0] IOE_ADDR0_OFS = 12'h434;
	localparam logic [11:0] IOE_ADDR1_OFS = 12'h438;
	localparam logic [11:0] IOE_IRQ_STS_OFS = 12'h440;
	localparam logic [11:0] IOE_IRQ_MSK_OFS = 12'h444;
	localparam logic [11:0] IOE_SEL_OFS = 12'h448;
	// field positions of the interface register
	localparam int IOE_DATA_LSB = 0;
	localparam int IOE_DATA_W = 16;
	localparam int IOE_REFRESH_BIT = 24;
	localparam int IOE_TM_BIT = 25;
	localparam int IOE_SEL_LSB = 26;
	localparam int IOE_SEL_W = 4;
	localparam int IOE_DONE_BIT = 31;
	// address fields
	localparam int IOE_A2_LSB = 17;
	localparam int IOE_A3_LSB = 25;
	localparam int IOE_A4_LSB = 1;
	localparam int IOE_BUSADDR_W = 7;
	// select codes
	localparam logic [3:0] IOE_SEL_TWO = 4'h2;
	localparam logic [3:0] IOE_SEL_THREE = 4'h3;
	localparam logic [3:0] IOE_SEL_FOUR = 4'h4;
	localparam int IOE_NUM = 3;
	// reset values
	localparam logic [31:0] IOE_ACCESS_RST = 32'h0000_0000;
	localparam logic [15:0] IOE_DIR_RST = 16'h00ff;
	// operation kinds sent to the smbus engine
	typedef enum logic [1:0] {
		IOE_OP_REFRESH = 2'h0,
		IOE_OP_WRITE_OUT = 2'h1,
		IOE_OP_INIT = 2'h2
	} ioe_op_t;
	// register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} ioe_bus_req_t;
	// request to the smbus engine
	typedef struct packed {
		logic valid;
		ioe_op_t op;
		logic [1:0] idx;
		logic [6:0] bus_addr;
		logic [15:0] out_val;
	} ioe_smb_req_t;
	// completion from the smbus engine
	typedef struct packed {
		logic done;
		logic [1:0] idx;
		logic [15:0] in_val;
	} ioe_smb_rsp_t;
endpackage

// File: ioe_pin_slot.sv
`timescale 1ns/1ps
// holds pin image of one expander
module ioe_pin_slot (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [15:0] dir_in,
	input wire logic [15:0] core_out,
	input wire logic test_mode,
	input wire logic sw_load,
	input wire logic [15:0] sw_val,
	input wire logic fetch_load,
	input wire logic [15:0] fetch_val,
	output logic [15:0] pins,
	output logic [15:0] drive_out
);
	import ioe_pkg::*;
	typedef struct packed {
		logic [15:0] sw_out;
		logic [15:0] in_img;
	} ioe_slot_st_t;
	ioe_slot_st_t st, next_st;
	// input bits only ever change by a fetch, never by software
	always_comb begin
		next_st = st;
		if (sw_load) begin
			next_st.sw_out = sw_val & ~dir_in;
		end
		if (fetch_load) begin
			next_st.in_img = fetch_val & dir_in;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	// outputs follow software in test mode, core otherwise
	assign drive_out = test_mode ? st.sw_out : (core_out & ~dir_in);
	assign pins = st.in_img | (drive_out & ~dir_in);
endmodule // ioe_pin_slot

// File: ioe_done_tracker.sv
`timescale 1ns/1ps
// sticky completion flag, set wins over clear
module ioe_done_tracker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic arm,
	input wire logic hit,
	input wire logic clear,
	output logic flag,
	output logic pending
);
	import ioe_pkg::*;
	typedef struct packed {
		logic flag;
		logic pending;
	} ioe_done_st_t;
	ioe_done_st_t st, next_st;
	always_comb begin
		next_st = st;
		if (clear) begin
			next_st.flag = 1'b0;
		end
		if (arm) begin
			next_st.pending = 1'b1;
		end
		if (st.pending && hit) begin
			next_st.flag = 1'b1;
			next_st.pending = arm;
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign flag = st.flag;
	assign pending = st.pending;
endmodule // ioe_done_tracker

// File: ioe_access.sv
`timescale 1ns/1ps
// Function
// - pin field reads selected expander pin state
// - pin field writes ignored outside test mode
// - test mode refresh sends software outputs
// - input bits of pin field stay read-only
// - refresh bit launches full smbus update
// - refresh bit self-clears, reads zero
// - test mode overrides core output values
// - read-only selector picks expander two-four
// - done flag after refresh transaction completes
// - done flag after test-mode pin write
// - done flag after address write init
// - hotplug writes in test mode set done
// - each expander has seven-bit bus address
module ioe_access (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [3:0] select_code,
	input wire logic [47:0] core_outputs,
	input wire logic [47:0] pin_dirs,
	input wire logic hotplug_write,
	output ioe_pkg::ioe_smb_req_t smb_req,
	input wire logic smb_ready,
	input wire ioe_pkg::ioe_smb_rsp_t smb_rsp,
	output logic [47:0] expander_outputs,
	output logic irq
);
	import ioe_pkg::*;
	// control state of this module, apart from the done flag and pending bit kept in u_done
	typedef struct packed {
		logic test_mode;
		logic [6:0] addr2;
		logic [6:0] addr3;
		logic [6:0] addr4;
		logic [3:0] sel;
		logic done_sts;
		logic done_msk;
		logic [31:0] rdata;
		ioe_smb_req_t req;
		logic [2:0] queued;
		logic [2:0] q_init;
		logic [2:0] q_out;
	} ioe_st_t;
	ioe_st_t st, next_st;
	logic [15:0] slot_pins [IOE_NUM];
	logic [15:0] slot_drive [IOE_NUM];
	logic [15:0] sel_pins;
	logic [1:0] sel_idx;
	logic sel_ok;
	logic wr_access, wr_addr0, wr_addr1, wr_sts;
	logic sw_pin_wr, refresh_wr, init_wr;
	logic done_flag, done_pending, done_arm, done_hit, done_clear;
	logic [6:0] addr_of [IOE_NUM];
	// decode selected expander, reserved codes select nothing
	always_comb begin
		sel_ok = 1'b1;
		sel_idx = 2'h0;
		unique case (st.sel)
			IOE_SEL_TWO: sel_idx = 2'h0;
			IOE_SEL_THREE: sel_idx = 2'h1;
			IOE_SEL_FOUR: sel_idx = 2'h2;
			default: sel_ok = 1'b0;
		endcase
	end
	assign sel_pins = sel_ok ? slot_pins[sel_idx] : 16'h0000;
	assign addr_of[0] = st.addr2;
	assign addr_of[1] = st.addr3;
	assign addr_of[2] = st.addr4;
	// write strobes per register
	assign wr_access = reg_wr && (reg_addr == IOE_ACCESS_OFS);
	assign wr_addr0 = reg_wr && (reg_addr == IOE_ADDR0_OFS);
	assign wr_addr1 = reg_wr && (reg_addr == IOE_ADDR1_OFS);
	assign wr_sts = reg_wr && (reg_addr == IOE_IRQ_STS_OFS);
	assign sw_pin_wr = wr_access && st.test_mode && sel_ok;
	assign refresh_wr = wr_access && reg_wdata[IOE_REFRESH_BIT] && sel_ok;
	assign init_wr = (wr_addr0 && (st.sel == IOE_SEL_TWO || st.sel == IOE_SEL_THREE))
		|| (wr_addr1 && st.sel == IOE_SEL_FOUR);
	// done arms on any operation aimed at the selected expander
	assign done_arm = refresh_wr || sw_pin_wr || (init_wr && sel_ok)
		|| (hotplug_write && st.test_mode && sel_ok);
	assign done_hit = smb_rsp.done && sel_ok && (smb_rsp.idx == sel_idx);
	assign done_clear = (wr_access && reg_wdata[IOE_DONE_BIT]) || (wr_sts && reg_wdata[0]);
	ioe_done_tracker u_done (
		.clk(clk),
		.rst_n(rst_n),
		.arm(done_arm),
		.hit(done_hit),
		.clear(done_clear),
		.flag(done_flag),
		.pending(done_pending)
	);
	// one pin image per expander
	for (genvar g = 0; g < IOE_NUM; g++) begin : g_slot
		ioe_pin_slot u_slot (
			.clk(clk),
			.rst_n(rst_n),
			.dir_in(pin_dirs[g*16 +: 16]),
			.core_out(core_outputs[g*16 +: 16]),
			.test_mode(st.test_mode),
			.sw_load(sw_pin_wr && (sel_idx == 2'(g))),
			.sw_val(reg_wdata[IOE_DATA_LSB +: IOE_DATA_W]),
			.fetch_load(smb_rsp.done && (smb_rsp.idx == 2'(g))),
			.fetch_val(smb_rsp.in_val),
			.pins(slot_pins[g]),
			.drive_out(slot_drive[g])
		);
		assign expander_outputs[g*16 +: 16] = slot_drive[g];
	end
	// register writes, queueing and smbus request issue
	always_comb begin
		logic [1:0] pick;
		logic found;
		pick = 2'h0;
		found = 1'b0;
		next_st = st;
		next_st.sel = select_code;
		if (wr_access) begin
			next_st.test_mode = reg_wdata[IOE_TM_BIT];
		end
		if (wr_addr0) begin
			next_st.addr2 = reg_wdata[IOE_A2_LSB +: IOE_BUSADDR_W];
			next_st.addr3 = reg_wdata[IOE_A3_LSB +: IOE_BUSADDR_W];
		end
		if (wr_addr1) begin
			next_st.addr4 = reg_wdata[IOE_A4_LSB +: IOE_BUSADDR_W];
		end
		if (reg_wr && reg_addr == IOE_IRQ_MSK_OFS) begin
			next_st.done_msk = reg_wdata[0];
		end
		// queue work; the refresh bit itself is never stored
		if (refresh_wr) begin
			next_st.queued[sel_idx] = 1'b1;
		end
		if (sw_pin_wr || (hotplug_write && st.test_mode && sel_ok)) begin
			next_st.q_out[sel_idx] = 1'b1;
		end
		if (wr_addr0) begin
			next_st.q_init[0] = 1'b1;
			next_st.q_init[1] = 1'b1;
		end
		if (wr_addr1) begin
			next_st.q_init[2] = 1'b1;
		end
		// hold request until the engine accepts it
		if (st.req.valid && smb_ready) begin
			next_st.req.valid = 1'b0;
		end
		if (!next_st.req.valid) begin
			for (int i = IOE_NUM - 1; i >= 0; i--) begin
				if (st.queued[i] || st.q_init[i] || st.q_out[i]) begin
					pick = 2'(i);
					found = 1'b1;
				end
			end
			if (found) begin
				next_st.req.valid = 1'b1;
				next_st.req.idx = pick;
				next_st.req.bus_addr = addr_of[pick];
				next_st.req.out_val = slot_drive[pick];
				if (st.q_init[pick]) begin
					next_st.req.op = IOE_OP_INIT;
				end else if (st.queued[pick]) begin
					next_st.req.op = IOE_OP_REFRESH;
				end else begin
					next_st.req.op = IOE_OP_WRITE_OUT;
				end
				next_st.q_init[pick] = 1'b0;
				next_st.queued[pick] = 1'b0;
				next_st.q_out[pick] = 1'b0;
			end
		end
		// sticky interrupt status sets with the done flag, cleared only by a status write, set wins
		if (wr_sts && reg_wdata[0]) begin
			next_st.done_sts = 1'b0;
		end
		if (done_pending && done_hit) begin
			next_st.done_sts = 1'b1;
		end
		// read data, one cycle after the strobe
		next_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				IOE_ACCESS_OFS: begin
					next_st.rdata[IOE_DATA_LSB +: IOE_DATA_W] = sel_pins;
					next_st.rdata[IOE_TM_BIT] = st.test_mode;
					next_st.rdata[IOE_SEL_LSB +: IOE_SEL_W] = st.sel;
					next_st.rdata[IOE_DONE_BIT] = done_flag;
				end
				IOE_ADDR0_OFS: begin
					next_st.rdata[IOE_A2_LSB +: IOE_BUSADDR_W] = st.addr2;
					next_st.rdata[IOE_A3_LSB +: IOE_BUSADDR_W] = st.addr3;
				end
				IOE_ADDR1_OFS: next_st.rdata[IOE_A4_LSB +: IOE_BUSADDR_W] = st.addr4;
				IOE_IRQ_STS_OFS: next_st.rdata[0] = st.done_sts;
				IOE_IRQ_MSK_OFS: next_st.rdata[0] = st.done_msk;
				default: next_st.rdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign reg_rdata = st.rdata;
	assign smb_req = st.req;
	assign irq = st.done_sts && st.done_msk;
endmodule // ioe_access

// File: ioe_access_monitor.sv
`timescale 1ns/1ps
// protocol watcher on the access block ports
module ioe_access_monitor (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] select_code,
	input wire logic [47:0] core_outputs,
	input wire logic [47:0] pin_dirs,
	input wire ioe_pkg::ioe_smb_req_t smb_req,
	input wire logic smb_ready,
	input wire logic [47:0] expander_outputs,
	input wire logic irq
);
	import ioe_pkg::*;
	logic tm_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// test mode shadow, rebuilt from bus writes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tm_q <= 1'b0;
		end else if (reg_wr && reg_addr == IOE_ACCESS_OFS) begin
			tm_q <= reg_wdata[IOE_TM_BIT];
		end
	end
	property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("rdata not zero when idle");
	property p_rsv; $past(reg_rd && reg_addr == IOE_ACCESS_OFS) |-> reg_rdata[24:16] == 9'h0 && !reg_rdata[30]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved or refresh bit reads set");
	property p_sel; $past(reg_rd && reg_addr == IOE_ACCESS_OFS) && $past(select_code) == $past(select_code, 2) |-> reg_rdata[29:26] == $past(select_code) && ($past(select_code) inside {4'h2, 4'h3, 4'h4} || reg_rdata[15:0] == 16'h0); endproperty
	a_sel: assert property (p_sel) else $error("selector field wrong");
	property p_hold; smb_req.valid && !smb_ready |=> smb_req.valid && $stable(smb_req); endproperty
	a_hold: assert property (p_hold) else $error("smbus request dropped early");
	property p_op; smb_req.valid |-> smb_req.op != 2'h3 && smb_req.idx < 2'h3; endproperty
	a_op: assert property (p_op) else $error("illegal smbus request");
	property p_outs; !tm_q |-> expander_outputs == (core_outputs & ~pin_dirs); endproperty
	a_outs: assert property (p_outs) else $error("outputs not from core");
	property p_launch; reg_wr && reg_addr == IOE_ACCESS_OFS && reg_wdata[IOE_REFRESH_BIT] && select_code inside {4'h2, 4'h3, 4'h4} |-> ##[1:40] smb_req.valid; endproperty
	a_launch: assert property (p_launch) else $error("refresh started nothing");
	property p_mask; reg_wr && reg_addr == IOE_IRQ_MSK_OFS && !reg_wdata[0] |-> ##2 !irq; endproperty
	a_mask: assert property (p_mask) else $error("irq high while masked");
endmodule // ioe_access_monitor
bind ioe_access ioe_access_monitor mon_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.select_code(select_code), .core_outputs(core_outputs), .pin_dirs(pin_dirs),
	.smb_req(smb_req), .smb_ready(smb_ready), .expander_outputs(expander_outputs), .irq(irq));

// File: ioe_smb_model.sv
`timescale 1ns/1ps
// far-side expander engine: one transaction at a time
module ioe_smb_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic [15:0] in_pins,
	input wire ioe_pkg::ioe_smb_req_t req,
	output logic ready,
	output logic [15:0] last_out,
	output logic [6:0] last_addr,
	output ioe_pkg::ioe_smb_rsp_t rsp
);
	import ioe_pkg::*;
	logic busy;
	logic [1:0] idx;
	logic [3:0] cnt;
	// slow mode stretches bus time so requests queue up behind it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy <= 1'b0;
			ready <= 1'b0;
			last_out <= 16'h0000;
			last_addr <= 7'h00;
			idx <= 2'h0;
			cnt <= 4'h0;
			rsp <= '0;
		end else begin
			ready <= req.valid && !ready && !busy;
			rsp.done <= 1'b0;
			// no stale answer between completions
			rsp.idx <= ~rsp.idx;
			rsp.in_val <= ~rsp.in_val;
			if (ready && req.valid) begin
				busy <= 1'b1;
				idx <= req.idx;
				// keep what was sent so the bench can check it
				last_out <= req.out_val;
				last_addr <= req.bus_addr;
				cnt <= slow ? 4'h9 : 4'h1;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				rsp <= '{1'b1, idx, in_pins};
			end
		end
	end
endmodule // ioe_smb_model

// File: ioe_access_tb.sv
`timescale 1ns/1ps
module ioe_access_tb;
	import ioe_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, hotplug_write, slow, irq, smb_ready;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0] select_code;
	logic [47:0] core_outputs, pin_dirs, expander_outputs;
	logic [15:0] rng, in_v, smb_out;
	logic [6:0] smb_addr;
	ioe_smb_req_t smb_req;
	ioe_smb_rsp_t smb_rsp;
	int n_errors, checks_done, m_tm, m_sel, m_pins;
	always #25 clk = ~clk;
	ioe_access dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .select_code(select_code),
		.core_outputs(core_outputs), .pin_dirs(pin_dirs), .hotplug_write(hotplug_write),
		.smb_req(smb_req), .smb_ready(smb_ready), .smb_rsp(smb_rsp),
		.expander_outputs(expander_outputs), .irq(irq));
	ioe_smb_model smb_u (.clk(clk), .rst_n(rst_n), .slow(slow), .in_pins(in_v), .req(smb_req),
		.ready(smb_ready), .last_out(smb_out), .last_addr(smb_addr), .rsp(smb_rsp));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// interface word as the bench model sees it; reserved selects hide pins
	function automatic logic [31:0] exp_acc(input int done);
		return 32'((done << 31) | (m_tm << 25) | (m_sel << 26) | ((m_sel inside {2, 3, 4}) ? m_pins : 0));
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	// read data stands one cycle only, so sample just after it lands
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
		@(posedge clk);
	endtask
	task automatic wait_irq(input logic v);
		for (int i = 0; i < 300 && irq !== v; i++) @(posedge clk);
		if (irq !== v) begin
			n_errors++;
			$display("ERROR irq expected %b seen %b", v, irq);
			print_verdict();
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{reg_wr, reg_rd, hotplug_write, slow} = 4'h0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		select_code = 4'h2;
		rng = lfsr(16'h002c);
		core_outputs = {rng, ~rng, rng};
		in_v = lfsr(rng);
		pin_dirs = {3{16'h00ff}};
		{m_tm, m_sel} = {32'd0, 32'd2};
		// before any transfer the field shows the core outputs being supplied
		m_pins = int'(core_outputs[15:0] & ~pin_dirs[15:0]);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdchk(IOE_ACCESS_OFS, exp_acc(0));
		rdchk(IOE_IRQ_MSK_OFS, 32'h0);
		wr(IOE_ACCESS_OFS, 32'h0000_ffff);
		rdchk(IOE_ACCESS_OFS, exp_acc(0));
		wr(IOE_IRQ_MSK_OFS, 32'h1);
		wr(IOE_ACCESS_OFS, 32'h0100_0000);
		wait_irq(1'b1);
		m_pins = (in_v & 16'h00ff) | (core_outputs[15:0] & 16'hff00);
		rdchk(IOE_ACCESS_OFS, exp_acc(1));
		wr(IOE_ACCESS_OFS, 32'h8000_0000);
		wr(IOE_IRQ_STS_OFS, 32'h1);
		rdchk(IOE_ACCESS_OFS, exp_acc(0));
		wait_irq(1'b0);
		slow <= 1'b1;
		wr(IOE_ADDR0_OFS, 32'h0054_0000);
		wait_irq(1'b1);
		rdchk(IOE_ACCESS_OFS, exp_acc(1));
		rdchk(IOE_ADDR0_OFS, 32'h0054_0000);
		wr(IOE_ACCESS_OFS, 32'h8000_0000);
		wr(IOE_IRQ_STS_OFS, 32'h1);
		wait_irq(1'b0);
		// enter test mode first: the same write may not load pins
		wr(IOE_ACCESS_OFS, 32'h0200_0000);
		m_tm = 1;
		wr(IOE_ACCESS_OFS, 32'h0200_a5a5);
		wait_irq(1'b1);
		m_pins = (m_pins & 16'h00ff) | 16'ha500;
		rdchk(IOE_ACCESS_OFS, exp_acc(1));
		chk("outputs", 32'ha500, 32'(expander_outputs[15:0] & 16'hff00));
		chk("smb_out_val", 32'ha500, 32'(smb_out));
		chk("smb_bus_addr", 32'h0000_002a, 32'(smb_addr));
		wr(IOE_IRQ_STS_OFS, 32'h1);
		wait_irq(1'b0);
		hotplug_write <= 1'b1;
		@(posedge clk);
		hotplug_write <= 1'b0;
		wait_irq(1'b1);
		wr(IOE_IRQ_MSK_OFS, 32'h0);
		wait_irq(1'b0);
		rdchk(IOE_IRQ_STS_OFS, 32'h1);
		select_code <= 4'h0;
		m_sel = 0;
		repeat (3) @(posedge clk);
		rdchk(IOE_ACCESS_OFS, exp_acc(1));
		// expander three: inputs fetched by its init, no software outputs yet
		select_code <= 4'h3;
		m_sel = 3;
		m_pins = int'(in_v & 16'h00ff);
		repeat (3) @(posedge clk);
		rdchk(IOE_ACCESS_OFS, exp_acc(1));
		print_verdict();
	end
endmodule // ioe_access_tb
